// ==== core/smw_pkg.sv ====
package smw_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Supervision times in nanoseconds
  // ----------------------------------------------------------------
  localparam int CORE_BLANK_NS = 1000;
  localparam int CORE_UV_DETECT_NS = 20000;
  localparam int CORE_RECOVERY_NS = 5000;
  localparam int IO_BLANK_NS = 1000;
  localparam int IO_UV_DETECT_NS = 20000;
  localparam int IO_RECOVERY_NS = 5000;
  localparam int POWER_TRANSITION_NS = 10000;
  localparam int WAKE_WINDOW_NS = 40000;
  localparam int WAKE_LOW_DETECT_NS = 1000;
  localparam int WAKE_IDLE_DETECT_NS = 1000;
  localparam int PAYLOAD_BIT_NS = 100;

  // ----------------------------------------------------------------
  // Cycle counts: least times round up, longest times round down
  // ----------------------------------------------------------------
  localparam logic [15:0] CORE_BLANK_CYC =
    16'((CORE_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CORE_DETECT_CYC =
    16'((CORE_UV_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CORE_REC_CYC =
    16'((CORE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] IO_BLANK_CYC =
    16'((IO_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] IO_DETECT_CYC =
    16'((IO_UV_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] IO_REC_CYC =
    16'((IO_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] POWER_CYC =
    16'(POWER_TRANSITION_NS / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_WIN_CYC =
    16'(WAKE_WINDOW_NS / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_LOW_CYC =
    16'((WAKE_LOW_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_IDLE_CYC =
    16'((WAKE_IDLE_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BIT_CYC = 4'(PAYLOAD_BIT_NS / CLK_PERIOD_NS);
  localparam logic [3:0] BIT_HALF = 4'(PAYLOAD_BIT_NS / CLK_PERIOD_NS / 2);

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam int ST_WAKE_BIT = 0;
  localparam int ST_MODE_BIT = 1;
  localparam int ST_PON_BIT = 4;
  localparam int ST_CORE_UV_BIT = 6;
  localparam int ST_IO_UV_BIT = 7;
  localparam int ST_ERR_BIT = 12;
  localparam int CT_PAT_EN_BIT = 0;
  localparam int CT_PAY_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [9:0] BYTE_LOW = 10'h200;
  localparam logic [9:0] BYTE_HIGH = 10'h2ff;

  typedef enum logic [1:0] {
    MD_OFF, MD_POWERUP, MD_STANDBY, MD_NORMAL
  } smw_mode_t;

endpackage

// ==== core/smw_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Undervoltage monitor for one supply
// ------------------------------------------------------------------
module smw_uv_mon #(
  parameter logic [15:0] BLK = 16'h0064,
  parameter logic [15:0] DET = 16'h07d0,
  parameter logic [15:0] REC = 16'h01f4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Comparator level, already synchronised
  input wire logic below,
  // Status
  output logic present_ff,
  output logic forced_ff,
  output logic det_p_ff
);
  logic [15:0] cnt_ff;
  logic [15:0] rcnt_ff;

  initial begin
    if (DET <= BLK || REC == 16'h0000) begin
      $error("smw_uv_mon: detect time must exceed blanking");
    end
  end

  // Blanking, detection and recovery timing share one process.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
      rcnt_ff <= 16'h0000;
      present_ff <= 1'b0;
      forced_ff <= 1'b0;
      det_p_ff <= 1'b0;
    end else if (ce) begin
      det_p_ff <= 1'b0;
      if (below) begin
        rcnt_ff <= 16'h0000;
        if (cnt_ff != DET) begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
        if (cnt_ff == BLK && !present_ff) begin
          present_ff <= 1'b1;
          det_p_ff <= 1'b1;
        end
        if (cnt_ff == DET - 16'h0001) begin
          forced_ff <= 1'b1;
        end
      end else begin
        cnt_ff <= 16'h0000;
        // A dip during recovery restarts the recovery time.
        if (present_ff) begin
          if (rcnt_ff == REC) begin
            present_ff <= 1'b0;
            forced_ff <= 1'b0;
            rcnt_ff <= 16'h0000;
          end else begin
            rcnt_ff <= rcnt_ff + 16'h0001;
          end
        end
      end
    end
  end
endmodule

// ------------------------------------------------------------------
// Supply mode and wake-up supervisor
// ------------------------------------------------------------------
module smw_supervisor
  import smw_pkg::*;
#(
  parameter int PAY_BYTES = 4,
  parameter logic [7:0] PAY_PATTERN = 8'h05
) (
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Supply comparators, high while below threshold
  input wire logic core_uv_in,
  input wire logic io_uv_in,
  input wire logic core_pd_in,
  // Host mode pin and bus receiver levels
  input wire logic standby_request_n,
  input wire logic bus_data0,
  input wire logic bus_data1,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Device outputs
  output logic error_wake_indicator_n,
  output logic rxd,
  output logic sdo_oe,
  output logic tx_enable,
  output logic interfaces_blocked,
  output logic normal_mode,
  output logic off_condition
);

  initial begin
    if (PAY_BYTES < 1 || PAY_BYTES > 8) begin
      $error("smw_supervisor: PAY_BYTES must be 1 to 8");
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic core_uv_s, io_uv_s, core_pd_s, standby_request_n_s, d0_s, d1_s;

  // Every pin input goes through two flip-flops before use.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else if (ce) begin
      sync1_ff <= {bus_data1, bus_data0, standby_request_n,
                   core_pd_in, io_uv_in, core_uv_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign {d1_s, d0_s, standby_request_n_s, core_pd_s, io_uv_s, core_uv_s} = sync2_ff;

  // ----------------------------------------------------------------
  // Supply monitors
  // ----------------------------------------------------------------
  logic core_present, core_forced, core_det_p;
  logic io_present, io_forced, io_det_p;

  smw_uv_mon #(.BLK(CORE_BLANK_CYC), .DET(CORE_DETECT_CYC),
               .REC(CORE_REC_CYC)) u_core_mon (
    .clk(clk), .rst(rst), .ce(ce), .below(core_uv_s),
    .present_ff(core_present), .forced_ff(core_forced),
    .det_p_ff(core_det_p)
  );

  smw_uv_mon #(.BLK(IO_BLANK_CYC), .DET(IO_DETECT_CYC),
               .REC(IO_REC_CYC)) u_io_mon (
    .clk(clk), .rst(rst), .ce(ce), .below(io_uv_s),
    .present_ff(io_present), .forced_ff(io_forced),
    .det_p_ff(io_det_p)
  );

  // During an I/O undervoltage the request pin reads as its default, low.
  logic host_req;
  assign host_req = standby_request_n_s && !io_present;

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  smw_mode_t mode_ff;
  logic [15:0] pcnt_ff;
  logic mode_chg;
  logic pon_p;
  logic supplies_ok;

  assign supplies_ok = !core_present && !io_present;
  assign pon_p = ce && mode_ff == MD_POWERUP && !core_pd_s &&
                 pcnt_ff == POWER_CYC;

  // Power-down wins over every other transition.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MD_OFF;
      pcnt_ff <= 16'h0000;
    end else if (ce) begin
      if (mode_ff != MD_OFF && core_pd_s) begin
        if (pcnt_ff >= POWER_CYC - 16'h0001) begin
          mode_ff <= MD_OFF;
          pcnt_ff <= 16'h0000;
        end else begin
          pcnt_ff <= pcnt_ff + 16'h0001;
        end
      end else begin
        unique case (mode_ff)
          MD_OFF: begin
            pcnt_ff <= 16'h0000;
            if (!core_pd_s) begin
              mode_ff <= MD_POWERUP;
            end
          end
          MD_POWERUP: begin
            if (pcnt_ff == POWER_CYC) begin
              mode_ff <= MD_STANDBY;
              pcnt_ff <= 16'h0000;
            end else begin
              pcnt_ff <= pcnt_ff + 16'h0001;
            end
          end
          MD_STANDBY: begin
            pcnt_ff <= 16'h0000;
            if (supplies_ok && host_req) begin
              mode_ff <= MD_NORMAL;
            end
          end
          MD_NORMAL: begin
            pcnt_ff <= 16'h0000;
            if (core_forced || io_forced || !host_req) begin
              mode_ff <= MD_STANDBY;
            end
          end
        endcase
      end
    end
  end

  assign mode_chg = ce && !core_pd_s &&
                    ((mode_ff == MD_STANDBY && supplies_ok && host_req) ||
                     (mode_ff == MD_NORMAL &&
                      (core_forced || io_forced || !host_req)));

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] ctrl_ff;

  // Writes are refused while an I/O undervoltage is present.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (ce && reg_wr && reg_addr == CTRL_OFS && !io_present) begin
      ctrl_ff <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Wake-up pattern detector
  // ----------------------------------------------------------------
  logic [15:0] lcnt_ff, hcnt_ff, wcnt_ff;
  logic armed_ff, sym_seen_ff, wake_pat_p_ff;

  // Idle and high both count as the second phase of a symbol.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcnt_ff <= 16'h0000;
      hcnt_ff <= 16'h0000;
      wcnt_ff <= 16'h0000;
      armed_ff <= 1'b0;
      sym_seen_ff <= 1'b0;
      wake_pat_p_ff <= 1'b0;
    end else if (ce) begin
      wake_pat_p_ff <= 1'b0;
      if (sym_seen_ff) begin
        wcnt_ff <= wcnt_ff + 16'h0001;
        if (wcnt_ff == WAKE_WIN_CYC) begin
          sym_seen_ff <= 1'b0;
        end
      end
      if (d0_s) begin
        hcnt_ff <= 16'h0000;
        armed_ff <= 1'b0;
        if (lcnt_ff != WAKE_LOW_CYC) begin
          lcnt_ff <= lcnt_ff + 16'h0001;
        end
      end else begin
        lcnt_ff <= 16'h0000;
        if (lcnt_ff == WAKE_LOW_CYC) begin
          armed_ff <= 1'b1;
        end
        if (armed_ff) begin
          if (hcnt_ff == WAKE_IDLE_CYC) begin
            armed_ff <= 1'b0;
            hcnt_ff <= 16'h0000;
            if (sym_seen_ff && wcnt_ff != WAKE_WIN_CYC) begin
              sym_seen_ff <= 1'b0;
              wake_pat_p_ff <= ctrl_ff[CT_PAT_EN_BIT];
            end else begin
              sym_seen_ff <= 1'b1;
              wcnt_ff <= 16'h0000;
            end
          end else begin
            hcnt_ff <= hcnt_ff + 16'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake-up payload detector
  // ----------------------------------------------------------------
  logic lvl;
  logic prev_lvl_ff;
  logic [3:0] bph_ff, bcnt_ff;
  logic [9:0] sh_ff;
  logic [2:0] nbyte_ff;
  logic wake_pay_p_ff;
  logic [9:0] sh_nxt;
  logic byte_hit;

  assign lvl = !d0_s;
  assign sh_nxt = {sh_ff[8:0], lvl};
  assign byte_hit = sh_nxt == BYTE_LOW || sh_nxt == BYTE_HIGH;

  // Bit phase follows every edge, so sampling stays mid-bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_lvl_ff <= 1'b1;
      bph_ff <= 4'h0;
      bcnt_ff <= 4'h0;
      sh_ff <= 10'h000;
      nbyte_ff <= 3'h0;
      wake_pay_p_ff <= 1'b0;
    end else if (ce) begin
      wake_pay_p_ff <= 1'b0;
      prev_lvl_ff <= lvl;
      if (lvl != prev_lvl_ff || bph_ff == BIT_CYC - 4'h1) begin
        bph_ff <= 4'h0;
      end else begin
        bph_ff <= bph_ff + 4'h1;
      end
      if (bph_ff == BIT_HALF) begin
        sh_ff <= sh_nxt;
        if (bcnt_ff != 4'hf) begin
          bcnt_ff <= bcnt_ff + 4'h1;
        end
        if (byte_hit && (nbyte_ff == 3'h0 || bcnt_ff == 4'h9)) begin
          bcnt_ff <= 4'h0;
          if (PAY_PATTERN[nbyte_ff] != sh_nxt[0]) begin
            nbyte_ff <= 3'h0;
          end else if (nbyte_ff == 3'(PAY_BYTES - 1)) begin
            nbyte_ff <= 3'h0;
            wake_pay_p_ff <= ctrl_ff[CT_PAY_EN_BIT];
          end else begin
            nbyte_ff <= nbyte_ff + 3'h1;
          end
        end else if (nbyte_ff != 3'h0 && bcnt_ff == 4'h9) begin
          nbyte_ff <= 3'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags: a set always wins over a clear
  // ----------------------------------------------------------------
  logic core_flag_ff, io_flag_ff, err_flag_ff, wake_flag_ff, pon_flag_ff;
  logic rd_ok, clr;
  logic wake_evt;

  assign rd_ok = ce && reg_rd && reg_addr == STATUS_OFS && !io_present;
  assign clr = rd_ok || mode_chg;
  assign wake_evt = (wake_pat_p_ff || wake_pay_p_ff) &&
                    mode_ff == MD_STANDBY;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_flag_ff <= 1'b0;
      io_flag_ff <= 1'b0;
      err_flag_ff <= 1'b0;
      wake_flag_ff <= 1'b0;
      pon_flag_ff <= 1'b0;
    end else if (ce) begin
      core_flag_ff <= core_det_p ||
                      (core_flag_ff && !(clr && !core_present));
      io_flag_ff <= io_det_p ||
                    (io_flag_ff && !(clr && !io_present));
      err_flag_ff <= core_det_p || (io_det_p && !core_present) ||
                     (err_flag_ff && !(clr && supplies_ok));
      wake_flag_ff <= wake_evt || (wake_flag_ff && !clr);
      // Only a read clears power-on; the automatic change to the requested
      // mode right after power-up would otherwise hide it from the host.
      pon_flag_ff <= pon_p || (pon_flag_ff && !rd_ok);
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic ind_low;
  assign ind_low = mode_ff == MD_OFF || mode_ff == MD_POWERUP ||
                   io_present ||
                   (mode_ff == MD_NORMAL && err_flag_ff) ||
                   (mode_ff == MD_STANDBY &&
                    (wake_flag_ff || core_flag_ff));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_wake_indicator_n <= 1'b0;
      rxd <= 1'b0;
      sdo_oe <= 1'b0;
      tx_enable <= 1'b0;
      interfaces_blocked <= 1'b1;
      normal_mode <= 1'b0;
      off_condition <= 1'b1;
    end else if (ce) begin
      error_wake_indicator_n <= !ind_low;
      rxd <= !io_present && mode_ff != MD_OFF &&
             (mode_ff == MD_NORMAL ? !d0_s : !wake_flag_ff);
      sdo_oe <= !io_present && mode_ff != MD_OFF;
      tx_enable <= mode_ff == MD_NORMAL && supplies_ok;
      interfaces_blocked <= io_present || mode_ff == MD_OFF ||
                            mode_ff == MD_POWERUP;
      normal_mode <= mode_ff == MD_NORMAL;
      off_condition <= mode_ff == MD_OFF;
    end
  end

  // Status flags read low while set, the mode bit reads high in normal mode; a blocked port reads zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= 16'h0000;
      if (rd_ok) begin
        reg_rdata[ST_WAKE_BIT] <= !wake_flag_ff;
        reg_rdata[ST_MODE_BIT] <= mode_ff == MD_NORMAL;
        reg_rdata[ST_PON_BIT] <= !pon_flag_ff;
        reg_rdata[ST_CORE_UV_BIT] <= !core_flag_ff;
        reg_rdata[ST_IO_UV_BIT] <= !io_flag_ff;
        reg_rdata[ST_ERR_BIT] <= !err_flag_ff;
      end else if (reg_rd && reg_addr == CTRL_OFS && !io_present) begin
        reg_rdata[1:0] <= ctrl_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_powerup_done;
    mode_ff == MD_POWERUP ##1 mode_ff == MD_STANDBY;
  endsequence

  a_core_flag_set: assert property (@(posedge clk) disable iff (rst)
    core_det_p && ce |=> core_flag_ff && err_flag_ff)
    else $error("core undervoltage did not set its flags");

  a_core_forces_sb: assert property (@(posedge clk) disable iff (rst)
    ce && core_forced && !core_pd_s && mode_ff == MD_NORMAL
      |=> mode_ff == MD_STANDBY)
    else $error("core undervoltage did not force standby");

  a_forced_no_norm: assert property (@(posedge clk) disable iff (rst)
    ce && io_forced && mode_ff != MD_NORMAL |=> mode_ff != MD_NORMAL)
    else $error("normal mode entered during forced standby");

  a_io_outputs_low: assert property (@(posedge clk) disable iff (rst)
    ce && io_present |=> !rxd && !error_wake_indicator_n && !sdo_oe)
    else $error("outputs not held low in io undervoltage");

  a_io_err_gated: assert property (@(posedge clk) disable iff (rst)
    ce && io_det_p && core_present && !err_flag_ff |=> !err_flag_ff)
    else $error("error flag set by io undervoltage under core fault");

  a_pon_flag_set: assert property (@(posedge clk) disable iff (rst)
    s_powerup_done |-> pon_flag_ff)
    else $error("power-on flag missing after power-up");

  a_powerup_bound: assert property (@(posedge clk) disable iff (rst)
    mode_ff == MD_POWERUP |-> pcnt_ff <= POWER_CYC)
    else $error("power-up took longer than allowed");

  a_wake_sb_only: assert property (@(posedge clk) disable iff (rst)
    $rose(wake_flag_ff) |-> $past(mode_ff) == MD_STANDBY)
    else $error("wake flagged outside standby");

  a_wake_two_sym: assert property (@(posedge clk) disable iff (rst)
    $rose(wake_pat_p_ff) |-> $past(sym_seen_ff))
    else $error("pattern wake accepted after one symbol");

  a_wake_reaction: assert property (@(posedge clk) disable iff (rst)
    ce && wake_evt ##1 ce |=> !error_wake_indicator_n && !rxd)
    else $error("wake not shown on outputs");

endmodule

`default_nettype wire

// ==== verification/smw_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// Host controller driving the mode pin
// ------------------------------------------------
module smw_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode wanted by the bench, high for normal
  input wire logic want_normal,
  // Mode pin
  output logic standby_request_n
);
  // The pin moves just after an edge, as a real port does.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_request_n <= 1'b1;
    end else begin
      standby_request_n <= want_normal;
    end
  end
endmodule

`default_nettype wire

// ==== verification/test_smw_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// Supervisor bench
// ------------------------------------------------
module test_smw_supervisor;
  import smw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic core_uv_in = 1'b0;
  logic io_uv_in = 1'b0;
  logic core_pd_in = 1'b1;
  logic want_normal = 1'b1;
  logic bus_data0 = 1'b0;
  logic bus_data1 = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ce = 1'b1;
  localparam int NBYTES = 4;
  localparam logic [7:0] PAT = 8'h05;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic standby_request_n, error_wake_indicator_n, rxd, sdo_oe;
  logic tx_enable, interfaces_blocked, normal_mode, off_condition;
  int fails = 0;
  int comparisons = 0;

  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  smw_host_model smw_host_model_i (.clk(clk), .rst(rst),
    .want_normal(want_normal), .standby_request_n(standby_request_n));

  smw_supervisor #(.PAY_BYTES(NBYTES), .PAY_PATTERN(PAT)) smw_supervisor_i (
    .clk(clk), .rst(rst), .ce(ce),
    .core_uv_in(core_uv_in), .io_uv_in(io_uv_in), .core_pd_in(core_pd_in),
    .standby_request_n(standby_request_n), .bus_data0(bus_data0),
    .bus_data1(bus_data1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .error_wake_indicator_n(error_wake_indicator_n), .rxd(rxd),
    .sdo_oe(sdo_oe), .tx_enable(tx_enable),
    .interfaces_blocked(interfaces_blocked), .normal_mode(normal_mode),
    .off_condition(off_condition));

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Bounded wait, since a hung mode machine must not stall the run.
  task automatic wait_normal(input logic lvl);
    for (int k = 0; k < 4000 && normal_mode !== lvl; k++) @(posedge clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // One symbol: dominant phase, then idle or the opposite level.
  task automatic wake_symbol(input logic alt);
    @(posedge clk);
    bus_data0 <= 1'b1;
    repeat (120) @(posedge clk);
    bus_data0 <= 1'b0;
    bus_data1 <= alt;
    repeat (120) @(posedge clk);
    bus_data1 <= 1'b0;
  endtask

  // One payload byte: start pair, then eight equal bits of one bit time.
  task automatic pay_byte(input logic v);
    bus_data0 <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    bus_data0 <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
    bus_data0 <= !v;
    repeat (8 * BIT_CYC) @(posedge clk);
    bus_data0 <= 1'b0;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_power_up();
    chk("off held", 1'b1, off_condition);
    core_pd_in <= 1'b0;
    wait_normal(1'b1);
    chk("off left", 1'b0, off_condition);
    chk("normal after power up", 1'b1, normal_mode);
    reg_read(STATUS_OFS);
    chk("power-on flag", 1'b0, rd_val[ST_PON_BIT]);
    chk("mode flag", 1'b1, rd_val[ST_MODE_BIT]);
  endtask

  task automatic test_regs();
    reg_read(CTRL_OFS);
    chk("ctrl reset", 1'b1, &rd_val[1:0]);
    reg_write(CTRL_OFS, 16'h0000);
    reg_read(CTRL_OFS);
    chk("ctrl written", 1'b0, |rd_val[1:0]);
    reg_write(CTRL_OFS, 16'h0003);
    reg_read(8'h08);
    chk("unmapped read", 1'b0, |rd_val);
  endtask

  task automatic test_core_uv();
    core_uv_in <= 1'b1;
    repeat (200) @(posedge clk);
    chk("tx disabled", 1'b0, tx_enable);
    chk("indicator core", 1'b0, error_wake_indicator_n);
    reg_read(STATUS_OFS);
    chk("core uv flag", 1'b0, rd_val[ST_CORE_UV_BIT]);
    chk("error flag", 1'b0, rd_val[ST_ERR_BIT]);
    repeat (2000) @(posedge clk);
    chk("core forced standby", 1'b0, normal_mode);
    core_uv_in <= 1'b0;
    repeat (400) @(posedge clk);
    chk("held in recovery", 1'b0, normal_mode);
    wait_normal(1'b1);
    chk("core released", 1'b1, normal_mode);
    repeat (10) @(posedge clk);
    chk("indicator cleared", 1'b1, error_wake_indicator_n);
  endtask

  task automatic test_io_uv();
    io_uv_in <= 1'b1;
    repeat (200) @(posedge clk);
    chk("blocked", 1'b1, interfaces_blocked);
    chk("rxd low", 1'b0, rxd);
    chk("indicator io", 1'b0, error_wake_indicator_n);
    chk("sdo released", 1'b0, sdo_oe);
    reg_read(STATUS_OFS);
    chk("blocked read", 1'b0, |rd_val);
    repeat (2000) @(posedge clk);
    chk("io forced standby", 1'b0, normal_mode);
    io_uv_in <= 1'b0;
    wait_normal(1'b1);
    chk("unblocked", 1'b0, interfaces_blocked);
    chk("io released", 1'b1, normal_mode);
  endtask

  task automatic test_wake();
    wake_symbol(1'b0);
    wake_symbol(1'b1);
    repeat (10) @(posedge clk);
    chk("no wake in normal", 1'b1, error_wake_indicator_n);
    want_normal <= 1'b0;
    wait_normal(1'b0);
    repeat (20) @(posedge clk);
    reg_read(STATUS_OFS);
    chk("no stale wake", 1'b1, rd_val[ST_WAKE_BIT]);
    wake_symbol(1'b0);
    chk("one symbol", 1'b1, error_wake_indicator_n);
    repeat (WAKE_WIN_CYC + 16'h0064) @(posedge clk);
    wake_symbol(1'b1);
    chk("lone symbol expired", 1'b1, error_wake_indicator_n);
    wake_symbol(1'b0);
    repeat (10) @(posedge clk);
    chk("wake indicator", 1'b0, error_wake_indicator_n);
    chk("wake rxd", 1'b0, rxd);
    reg_read(STATUS_OFS);
    chk("wake flag", 1'b0, rd_val[ST_WAKE_BIT]);
  endtask

  // Payload wake: refused while disabled or mismatched, then taken.
  task automatic test_payload();
    reg_write(CTRL_OFS, 16'h0001);
    for (int i = 0; i < NBYTES; i++) pay_byte(PAT[i]);
    repeat (200) @(posedge clk);
    chk("payload disabled", 1'b1, error_wake_indicator_n);
    reg_write(CTRL_OFS, 16'h0003);
    for (int i = 0; i < NBYTES; i++) pay_byte(!PAT[i]);
    repeat (200) @(posedge clk);
    chk("payload mismatch", 1'b1, error_wake_indicator_n);
    for (int i = 0; i < NBYTES; i++) pay_byte(PAT[i]);
    repeat (10) @(posedge clk);
    chk("payload wake", 1'b0, error_wake_indicator_n);
    reg_read(STATUS_OFS);
    chk("payload flag", 1'b0, rd_val[ST_WAKE_BIT]);
  endtask

  // A low clock enable must hold off the power-down sequence.
  task automatic test_power_down();
    core_pd_in <= 1'b1;
    ce <= 1'b0;
    repeat (POWER_CYC + 16'h000a) @(posedge clk);
    chk("frozen by enable", 1'b0, off_condition);
    ce <= 1'b1;
    repeat (POWER_CYC + 16'h000a) @(posedge clk);
    chk("off after power down", 1'b1, off_condition);
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence after a 16 cycle reset.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_power_up();
    test_regs();
    test_core_uv();
    test_io_uv();
    test_wake();
    test_payload();
    test_power_down();
    complete_run();
  end

  // Watchdog well past the roughly 15000 cycles the tests take.
  initial begin
    #500000;
    fails++;
    complete_run();
  end
endmodule

`default_nettype wire
